//--- core/pdrd_reg_decode.sv
`timescale 1ns/1ps
module pdrd_reg_decode
   import pdrd_pkg::*;
(
   // clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 srst_i,
   // section base addresses
   input  wire logic [15:0]          bridge_base_i,
   input  wire logic [15:0]          timer_base_i,
   input  wire logic [15:0]          ctrl_base_i,
   input  wire logic [15:0]          dio_base_i,
   input  wire logic [15:0]          adda_base_i,
   // host i/o cycle
   input  wire logic [15:0]          io_addr_i,
   input  wire logic                 io_wr_i,
   input  wire logic                 io_rd_i,
   input  wire logic [3:0]           io_be_i,
   input  wire logic [31:0]          io_wdata_i,
   output logic                      io_ack_o,
   output logic [31:0]               io_rdata_o,
   output logic                      io_rvalid_o,
   // add-on side and interrupt
   input  wire logic                 addon_irq_i,
   output logic [31:0]               mbox_o,
   output logic                      mbox_armed_o,
   output logic                      host_irq_o,
   // counter section
   output logic [3:0]                counter_wr_o,
   output logic [7:0]                counter_wdata_o,
   output logic [2:0]                counter_rd_o,
   input  wire logic [23:0]          counter_rdata_i,
   // control and status section
   output logic [15:0]               acq_ctrl_o,
   output logic                      acq_ctrl_wr_o,
   input  wire logic [15:0]          acq_status_i,
   output logic                      soft_trig_o,
   // digital i/o section
   output logic [15:0]               dout_o,
   input  wire logic [15:0]          din_i,
   // converter section
   input  wire logic [15:0]          ad_data_i,
   output logic                      ad_rd_o,
   output logic [15:0]               da1_o,
   output logic [15:0]               da2_o
);
   import pdrd_pkg::*;

   pdrd_st_t          q;
   pdrd_st_t          d;
   logic [15:0]       base_w [NSECT];
   logic [NSECT-1:0]  hit_w;
   logic [5:0]        off_w [NSECT];
   logic [7:0]        nv_mem [NV_DEPTH];
   logic [7:0]        cmd_b;
   logic [7:0]        dat_b;
   logic [5:0]        wo;

   // picks one byte lane of a dword; used for command and data lanes
   function automatic logic [7:0] lane(input logic [31:0] w, input int idx);
      lane = w[8*idx +: 8];
   endfunction : lane

   // nvram index from the two address bytes; upper bits beyond depth dropped
   function automatic logic [NV_AW-1:0] nv_index(input logic [7:0] hi,
                                                 input logic [7:0] lo);
      nv_index = NV_AW'({hi, lo});
   endfunction : nv_index

   // one decoder per relocatable section
   assign base_w[SEC_BRIDGE] = bridge_base_i;
   assign base_w[SEC_TIMER]  = timer_base_i;
   assign base_w[SEC_CTRL]   = ctrl_base_i;
   assign base_w[SEC_DIO]    = dio_base_i;
   assign base_w[SEC_ADDA]   = adda_base_i;

   for (genvar g = 0; g < NSECT; g++)
   begin : g_sect
      pdrd_sect_dec #(
         .SPAN ((g == SEC_BRIDGE) ? SPAN_BRIDGE : SPAN_OTHER)
      ) u_dec (
         .base_i (base_w[g]),
         .addr_i (io_addr_i),
         .hit_o  (hit_w[g]),
         .off_o  (off_w[g])
      );
   end

   // cycle is acknowledged only when some section claims it
   assign io_ack_o = (io_wr_i | io_rd_i) & (|hit_w);
   assign cmd_b    = lane(io_wdata_i, LANE_NVCMD);
   assign dat_b    = lane(io_wdata_i, LANE_NVDATA);

   // next-state logic; lowest section index wins if bases overlap
   always_comb
   begin
      d        = q;
      wo       = '0;
      d.acq_wr = 1'b0;
      d.trig   = 1'b0;
      d.ad_rd  = 1'b0;
      d.cnt_wr = '0;
      d.cnt_rd = '0;
      d.nv_we  = 1'b0;
      d.rvalid = 1'b0;

      // add-on event: clear of armed wins over any arm write below
      if (addon_irq_i)
      begin
         d.armed = 1'b0;
      end

      // nvram busy countdown
      if (q.nvst == NV_BUSY_WR || q.nvst == NV_BUSY_RD)
      begin
         if (q.nv_cnt == NV_CNT_ZERO)
         begin
            d.nvst = NV_IDLE;
            if (q.nvst == NV_BUSY_RD)
            begin
               d.nv_dat = nv_mem[nv_index(q.nv_hi, q.nv_lo)];
            end
            else
            begin
               d.nv_we = 1'b1;
            end
         end
         else
         begin
            d.nv_cnt = q.nv_cnt - NV_CNT_STEP;
         end
      end

      // writes: direction alone selects the write register
      if (io_wr_i)
      begin
         if (hit_w[SEC_BRIDGE])
         begin
            wo = {off_w[SEC_BRIDGE][5:2], 2'b00};
            if (wo == OFF_MBOX)
            begin
               d.mbox = io_wdata_i;
               if (io_wdata_i == MBOX_ARM_VAL)
               begin
                  d.armed = ~addon_irq_i;
               end
            end
            else if (wo == OFF_INTCTL)
            begin
               if (io_wdata_i == INT_ENABLE_VAL)
               begin
                  d.int_en = 1'b1;
               end
               else if (io_wdata_i == INT_DISABLE_VAL)
               begin
                  d.int_en = 1'b0;
               end
               // enable, re-enable and disable all drop the pending flag
               if (io_wdata_i == INT_ENABLE_VAL || io_wdata_i == INT_DISABLE_VAL)
               begin
                  d.int_stat = 1'b0;
               end
            end
            else if (wo == OFF_NVCTL)
            begin
               // commands while busy are ignored; host is expected to poll
               if (io_be_i[LANE_NVCMD] && !(q.nvst == NV_BUSY_WR ||
                                            q.nvst == NV_BUSY_RD))
               begin
                  unique case (cmd_b)
                     NV_CMD_LO:    d.nvst = NV_LOAD_LO;
                     NV_CMD_HI:    d.nvst = NV_LOAD_HI;
                     NV_CMD_WRITE: d.nvst = NV_WRITE_ARM;
                     NV_CMD_READ:
                     begin
                        d.nvst   = NV_BUSY_RD;
                        d.nv_cnt = NV_CNT_LOAD;
                     end
                     default:      d.nvst = q.nvst;
                  endcase
               end
               // data byte only counts once a command stands
               else if (io_be_i[LANE_NVDATA])
               begin
                  unique case (q.nvst)
                     NV_LOAD_LO:
                     begin
                        d.nv_lo = dat_b;
                        d.nvst  = NV_IDLE;
                     end
                     NV_LOAD_HI:
                     begin
                        d.nv_hi = dat_b;
                        d.nvst  = NV_IDLE;
                     end
                     NV_WRITE_ARM:
                     begin
                        d.nv_dat = dat_b;
                        d.nvst   = NV_BUSY_WR;
                        d.nv_cnt = NV_CNT_LOAD;
                     end
                     default: d.nvst = q.nvst;
                  endcase
               end
            end
         end
         else if (hit_w[SEC_TIMER])
         begin
            d.cnt_wr[off_w[SEC_TIMER][3:2]] = 1'b1;
            d.cnt_wdata = io_wdata_i[7:0];
         end
         else if (hit_w[SEC_CTRL])
         begin
            wo = {off_w[SEC_CTRL][5:2], 2'b00};
            if (wo == OFF_ACQ)
            begin
               d.acq    = io_wdata_i[15:0];
               d.acq_wr = 1'b1;
            end
            else if (wo == OFF_TRIG)
            begin
               d.trig = 1'b1;
            end
         end
         else if (hit_w[SEC_DIO])
         begin
            if ({off_w[SEC_DIO][5:2], 2'b00} == OFF_DIO)
            begin
               d.dout = io_wdata_i[15:0];
            end
         end
         else if (hit_w[SEC_ADDA])
         begin
            wo = {off_w[SEC_ADDA][5:2], 2'b00};
            if (wo == OFF_AD)
            begin
               d.da1 = io_wdata_i[15:0];
            end
            else if (wo == OFF_DA2)
            begin
               d.da2 = io_wdata_i[15:0];
            end
         end
      end
      // reads: unmapped and write-only locations return zero
      else if (io_rd_i)
      begin
         d.rvalid = 1'b1;
         d.rdata  = '0;
         if (hit_w[SEC_BRIDGE])
         begin
            wo = {off_w[SEC_BRIDGE][5:2], 2'b00};
            if (wo == OFF_INTCTL)
            begin
               d.rdata[INT_STAT_BIT] = q.int_stat;
               d.rdata[INT_EN_BIT]   = q.int_en;
            end
            else if (wo == OFF_NVCTL)
            begin
               d.rdata[8*LANE_NVCMD + NV_BUSY_BIT] =
                  (q.nvst == NV_BUSY_WR || q.nvst == NV_BUSY_RD);
               d.rdata[8*LANE_NVDATA +: 8] = q.nv_dat;
            end
            // other bridge ports belong to the bridge itself
         end
         else if (hit_w[SEC_TIMER])
         begin
            if (off_w[SEC_TIMER][3:2] < 2'(NCNT))
            begin
               d.rdata[7:0] = counter_rdata_i[8*off_w[SEC_TIMER][3:2] +: 8];
               d.cnt_rd[off_w[SEC_TIMER][3:2]] = 1'b1;
            end
         end
         else if (hit_w[SEC_CTRL])
         begin
            if ({off_w[SEC_CTRL][5:2], 2'b00} == OFF_ACQ)
            begin
               d.rdata[15:0] = acq_status_i;
            end
         end
         else if (hit_w[SEC_DIO])
         begin
            if ({off_w[SEC_DIO][5:2], 2'b00} == OFF_DIO)
            begin
               d.rdata[15:0] = din_i;
            end
         end
         else if (hit_w[SEC_ADDA])
         begin
            if ({off_w[SEC_ADDA][5:2], 2'b00} == OFF_AD)
            begin
               d.rdata[15:0] = ad_data_i;
               d.ad_rd       = 1'b1;
            end
         end
      end

      // add-on event sets pending status last, only while enabled, so it beats an enable-write clear
      if (addon_irq_i && d.int_en)
      begin
         d.int_stat = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         q <= RST_ST;
      end
      else
      begin
         q <= d;
      end
   end

   // nvram storage; write lands one cycle after busy ends
   always_ff @(posedge clock_i)
   begin
      if (q.nv_we)
      begin
         nv_mem[nv_index(q.nv_hi, q.nv_lo)] <= q.nv_dat;
      end
   end

   // outputs straight from state
   assign io_rdata_o      = q.rdata;
   assign io_rvalid_o     = q.rvalid;
   assign mbox_o          = q.mbox;
   assign mbox_armed_o    = q.armed;
   assign host_irq_o      = q.int_en & q.int_stat;
   assign counter_wr_o    = q.cnt_wr;
   assign counter_wdata_o = q.cnt_wdata;
   assign counter_rd_o    = q.cnt_rd;
   assign acq_ctrl_o      = q.acq;
   assign acq_ctrl_wr_o   = q.acq_wr;
   assign soft_trig_o     = q.trig;
   assign dout_o          = q.dout;
   assign ad_rd_o         = q.ad_rd;
   assign da1_o           = q.da1;
   assign da2_o           = q.da2;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   logic br_wr;
   logic br_rd;
   logic nv_busy;
   assign br_wr   = io_wr_i & hit_w[SEC_BRIDGE];
   assign br_rd   = io_rd_i & ~io_wr_i & hit_w[SEC_BRIDGE];
   assign nv_busy = io_rdata_o[8*LANE_NVCMD + NV_BUSY_BIT];

   dio_place_a: assert property (io_wr_i && hit_w == (NSECT'(1) << SEC_DIO) &&
      off_w[SEC_DIO] == OFF_DIO |=> dout_o == $past(io_wdata_i[15:0]))
      else $error("digital output not written at its own base");
   bridge_rsvd_a: assert property (br_rd && off_w[SEC_BRIDGE][5:2] != OFF_INTCTL[5:2] &&
      off_w[SEC_BRIDGE][5:2] != OFF_NVCTL[5:2] |=> io_rdata_o == '0)
      else $error("reserved bridge port returned data");
   mbox_arm_a: assert property (br_wr && off_w[SEC_BRIDGE] == OFF_MBOX &&
      io_wdata_i == MBOX_ARM_VAL && !addon_irq_i |=> mbox_armed_o && mbox_o == '0)
      else $error("mailbox zero write did not arm");
   int_enable_a: assert property (br_wr && off_w[SEC_BRIDGE] == OFF_INTCTL &&
      io_wdata_i == INT_ENABLE_VAL && !addon_irq_i ##1 addon_irq_i && !br_wr
      |=> host_irq_o)
      else $error("enabled interrupt not raised on add-on event");
   int_disable_a: assert property (br_wr && off_w[SEC_BRIDGE] == OFF_INTCTL &&
      io_wdata_i == INT_DISABLE_VAL ##1 !br_wr |-> !host_irq_o [*2])
      else $error("interrupt request after disable");
   int_stat_a: assert property (br_rd && off_w[SEC_BRIDGE] == OFF_INTCTL
      |=> io_rvalid_o && io_rdata_o[INT_STAT_BIT] == $past(q.int_stat))
      else $error("interrupt status read wrong");
   irq_stat_a: assert property (addon_irq_i && q.int_en && !br_wr
      |=> host_irq_o && q.int_stat)
      else $error("add-on event did not raise the interrupt");
   nv_busy_a: assert property (br_wr && off_w[SEC_BRIDGE][5:2] == OFF_NVCTL[5:2] &&
      io_be_i[LANE_NVCMD] && cmd_b == NV_CMD_READ && q.nvst == NV_IDLE
      |=> (q.nvst == NV_BUSY_RD) [*8] ##1 q.nvst == NV_IDLE)
      else $error("nvram read busy period wrong");
   nv_lo_a: assert property (br_wr && off_w[SEC_BRIDGE][5:2] == OFF_NVCTL[5:2] &&
      !io_be_i[LANE_NVCMD] && io_be_i[LANE_NVDATA] && q.nvst == NV_LOAD_LO
      |=> q.nv_lo == $past(dat_b) && q.nvst == NV_IDLE)
      else $error("nvram low address not loaded");
   nv_status_a: assert property (br_rd && off_w[SEC_BRIDGE][5:2] == OFF_NVCTL[5:2]
      |=> nv_busy == $past(q.nvst == NV_BUSY_WR || q.nvst == NV_BUSY_RD))
      else $error("nvram busy flag read wrong");
   dio_dir_a: assert property (io_rd_i && !io_wr_i && hit_w[SEC_DIO] &&
      !hit_w[SEC_BRIDGE] && !hit_w[SEC_TIMER] && !hit_w[SEC_CTRL] &&
      off_w[SEC_DIO] == OFF_DIO |=> io_rdata_o[15:0] == $past(din_i) && $stable(dout_o))
      else $error("read disturbed the output register");

   irq_seen_c:  cover property (host_irq_o);
   nv_read_c:   cover property (q.nvst == NV_BUSY_RD ##1 q.nvst == NV_IDLE);
   nv_write_c:  cover property (q.nv_we);
   dio_loop_c:  cover property (io_rvalid_o && hit_w[SEC_DIO]);
endmodule : pdrd_reg_decode

//--- core/pdrd_pkg.sv
package pdrd_pkg;
   // host i/o cycle geometry
   localparam int IO_AW = 16;
   localparam int NSECT = 5;
   localparam int SEC_BRIDGE = 0;
   localparam int SEC_TIMER  = 1;
   localparam int SEC_CTRL   = 2;
   localparam int SEC_DIO    = 3;
   localparam int SEC_ADDA   = 4;
   localparam logic [15:0] SPAN_BRIDGE = 16'h0040;
   localparam logic [15:0] SPAN_OTHER  = 16'h0010;

   // bridge section offsets
   localparam logic [5:0] OFF_MBOX   = 6'h00;
   localparam logic [5:0] OFF_INTCTL = 6'h38;
   localparam logic [5:0] OFF_NVCTL  = 6'h3c;
   localparam logic [5:0] OFF_NVDATA = 6'h3e;
   localparam logic [5:0] OFF_NVCMD  = 6'h3f;
   localparam int LANE_NVDATA = 2;
   localparam int LANE_NVCMD  = 3;

   // other sections
   localparam logic [5:0] OFF_CNT0    = 6'h00;
   localparam logic [5:0] OFF_CNT1    = 6'h04;
   localparam logic [5:0] OFF_CNT2    = 6'h08;
   localparam logic [5:0] OFF_CNTMODE = 6'h0c;
   localparam logic [5:0] OFF_ACQ     = 6'h00;
   localparam logic [5:0] OFF_TRIG    = 6'h04;
   localparam logic [5:0] OFF_DIO     = 6'h00;
   localparam logic [5:0] OFF_AD      = 6'h00;
   localparam logic [5:0] OFF_DA2     = 6'h04;
   localparam int NCNT = 3;

   // target interrupt control
   localparam logic [31:0] INT_ENABLE_VAL  = 32'h0001_0010;
   localparam logic [31:0] INT_DISABLE_VAL = 32'h0000_0000;
   localparam logic [31:0] MBOX_ARM_VAL    = 32'h0000_0000;
   localparam int INT_STAT_BIT = 16;
   localparam int INT_EN_BIT   = 4;

   // nonvolatile memory commands
   localparam logic [7:0] NV_CMD_LO    = 8'h80;
   localparam logic [7:0] NV_CMD_HI    = 8'ha0;
   localparam logic [7:0] NV_CMD_WRITE = 8'hc0;
   localparam logic [7:0] NV_CMD_READ  = 8'he0;
   localparam int NV_BUSY_BIT = 7;
   localparam int NV_AW       = 9;
   localparam int NV_DEPTH    = 512;
   localparam int CLK_NS      = 100;
   localparam int NV_BUSY_NS  = 800;
   localparam int NV_BUSY_CYC = (NV_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] NV_CNT_LOAD = 4'(NV_BUSY_CYC - 1);
   localparam logic [3:0] NV_CNT_ZERO = 4'h0;
   localparam logic [3:0] NV_CNT_STEP = 4'h1;

   typedef enum logic [2:0] {
      NV_IDLE, NV_LOAD_LO, NV_LOAD_HI, NV_WRITE_ARM, NV_BUSY_WR, NV_BUSY_RD
   } pdrd_nvst_t;

   typedef struct packed {
      logic [31:0] mbox;
      logic        armed;
      logic        int_en;
      logic        int_stat;
      pdrd_nvst_t  nvst;
      logic [3:0]  nv_cnt;
      logic [7:0]  nv_lo;
      logic [7:0]  nv_hi;
      logic [7:0]  nv_dat;
      logic        nv_we;
      logic [15:0] acq;
      logic [15:0] dout;
      logic [15:0] da1;
      logic [15:0] da2;
      logic        acq_wr;
      logic        trig;
      logic        ad_rd;
      logic [3:0]  cnt_wr;
      logic [2:0]  cnt_rd;
      logic [7:0]  cnt_wdata;
      logic [31:0] rdata;
      logic        rvalid;
   } pdrd_st_t;

   localparam pdrd_st_t RST_ST = '0;
endpackage : pdrd_pkg

//--- core/pdrd_sect_dec.sv
`timescale 1ns/1ps
module pdrd_sect_dec #(
   parameter logic [15:0] SPAN = 16'h0010
) (
   // section base and cycle address
   input  wire logic [15:0] base_i,
   input  wire logic [15:0] addr_i,
   // decode result
   output logic             hit_o,
   output logic [5:0]       off_o
);
   localparam logic [15:0] MASK = SPAN - 16'h0001;

   // base is taken as aligned to the span; low bits of base are ignored
   assign hit_o = (addr_i & ~MASK) == (base_i & ~MASK);
   assign off_o = 6'(addr_i & MASK);
endmodule : pdrd_sect_dec

//--- dv/pdrd_periph_model.sv
`timescale 1ns/1ps
module pdrd_periph_model (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // from the decode
   input  wire logic [15:0] dout_i,
   input  wire logic [15:0] acq_ctrl_i,
   input  wire logic        ad_rd_i,
   // back to the decode
   output logic      [15:0] din_o,
   output logic      [15:0] acq_status_o,
   output logic      [23:0] counter_rdata_o,
   output logic      [15:0] ad_data_o
);
   // inverted loopback, so a read that returns the output latch is caught
   assign din_o = ~dout_i;
   assign acq_status_o = acq_ctrl_i ^ 16'h00ff;
   assign counter_rdata_o = 24'h332211;
   // converter fifo: each pop presents the next sample
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         ad_data_o <= 16'h0123;
      else if (ad_rd_i)
         ad_data_o <= ad_data_o + 16'h0001;
   end
endmodule : pdrd_periph_model

//--- dv/tb_pdrd_reg_decode.sv
`timescale 1ns/1ps
module tb_pdrd_reg_decode;
   import pdrd_pkg::*;
   localparam logic [15:0] BR = 16'h1000;
   localparam logic [15:0] TM = 16'h2000;
   localparam logic [15:0] CT = 16'h2010;
   localparam logic [15:0] AD = 16'h2030;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [15:0] dio_base = 16'h2020;
   logic [15:0] io_addr_i = 16'h0;
   logic        io_wr_i = 1'b0;
   logic        io_rd_i = 1'b0;
   logic [3:0]  io_be_i = 4'h0;
   logic [31:0] io_wdata_i = 32'h0;
   logic        addon_irq_i = 1'b0;
   logic        io_ack_o, io_rvalid_o, mbox_armed_o, host_irq_o;
   logic        acq_ctrl_wr_o, soft_trig_o, ad_rd_o;
   logic [31:0] io_rdata_o, mbox_o;
   logic [3:0]  counter_wr_o;
   logic [7:0]  counter_wdata_o;
   logic [2:0]  counter_rd_o;
   logic [15:0] acq_ctrl_o, acq_status_i, dout_o, din_i, ad_data_i, da1_o, da2_o;
   logic [23:0] counter_rdata_i;
   int          fail_count = 0;
   int          n_compared = 0;

   pdrd_reg_decode pdrd_reg_decode_inst (.clock_i(clock_i), .srst_i(srst_i),
      .bridge_base_i(BR), .timer_base_i(TM), .ctrl_base_i(CT), .dio_base_i(dio_base),
      .adda_base_i(AD), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_be_i(io_be_i), .io_wdata_i(io_wdata_i), .io_ack_o(io_ack_o),
      .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .addon_irq_i(addon_irq_i),
      .mbox_o(mbox_o), .mbox_armed_o(mbox_armed_o), .host_irq_o(host_irq_o),
      .counter_wr_o(counter_wr_o), .counter_wdata_o(counter_wdata_o),
      .counter_rd_o(counter_rd_o), .counter_rdata_i(counter_rdata_i),
      .acq_ctrl_o(acq_ctrl_o), .acq_ctrl_wr_o(acq_ctrl_wr_o), .acq_status_i(acq_status_i),
      .soft_trig_o(soft_trig_o), .dout_o(dout_o), .din_i(din_i), .ad_data_i(ad_data_i),
      .ad_rd_o(ad_rd_o), .da1_o(da1_o), .da2_o(da2_o));

   pdrd_periph_model pdrd_periph_model_inst (.clock_i(clock_i), .srst_i(srst_i),
      .dout_i(dout_o), .acq_ctrl_i(acq_ctrl_o), .ad_rd_i(ad_rd_o), .din_o(din_i),
      .acq_status_o(acq_status_i), .counter_rdata_o(counter_rdata_i),
      .ad_data_o(ad_data_i));

   // 100 ns clock
   initial
   begin
      forever #50 clock_i = ~clock_i;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one strobe cycle; ack is combinational so it is looked at mid-cycle
   task automatic cyc(input logic w, input logic [15:0] a, input logic [3:0] be,
                      input logic [31:0] d, input logic ack);
      @(posedge clock_i);
      #1;
      io_wr_i = w;
      io_rd_i = ~w;
      io_addr_i = a;
      io_be_i = be;
      io_wdata_i = d;
      #40;
      chk("ack", 32'(ack), 32'(io_ack_o));
      @(posedge clock_i);
      #1;
      io_wr_i = 1'b0;
      io_rd_i = 1'b0;
   endtask : cyc

   task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
      cyc(1'b1, a, be, d, 1'b1);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [3:0] be, input logic [31:0] m,
                     input logic [31:0] e, input string n);
      cyc(1'b0, a, be, 32'h0, 1'b1);
      chk("rvalid", 32'h1, 32'(io_rvalid_o));
      chk(n, e, io_rdata_o & m);
   endtask : rd

   task automatic irq_pulse();
      @(posedge clock_i);
      #1;
      addon_irq_i = 1'b1;
      @(posedge clock_i);
      #1;
      addon_irq_i = 1'b0;
   endtask : irq_pulse

   // poll busy under a bound; the host never stacks commands on a busy memory
   task automatic nv_wait();
      int k;
      k = 0;
      do
      begin
         cyc(1'b0, BR + OFF_NVCTL, 4'h8, 32'h0, 1'b1);
         k++;
      end while (io_rdata_o[31] !== 1'b0 && k < 20);
      chk("nv ready", 32'h0, 32'(io_rdata_o[31]));
   endtask : nv_wait

   // command byte first, then the byte on the data lane
   task automatic nv_op(input logic [7:0] c, input logic [7:0] b);
      wr(BR + OFF_NVCTL, 4'h8, {c, 24'h0});
      wr(BR + OFF_NVCTL, 4'h4, {8'h0, b, 16'h0});
   endtask : nv_op

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // watchdog well past the few hundred cycles the tests need
   initial
   begin
      repeat (5000) @(posedge clock_i);
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      repeat (20) @(posedge clock_i);
      #1;
      srst_i = 1'b0;
      chk("irq after reset", 32'h0, 32'(host_irq_o));
      wr(BR + OFF_MBOX, 4'hf, MBOX_ARM_VAL);
      chk("armed", 32'h1, 32'(mbox_armed_o));
      rd(BR + OFF_MBOX, 4'hf, '1, 32'h0, "mbox read");
      irq_pulse();
      chk("armed clear", 32'h0, 32'(mbox_armed_o));
      wr(BR + OFF_MBOX, 4'hf, 32'hdead_beef);
      chk("mbox", 32'hdead_beef, mbox_o);
      chk("armed stays", 32'h0, 32'(mbox_armed_o));
      rd(BR + 16'h0010, 4'hf, '1, 32'h0, "reserved");
      // enable, take an event, re-enable, disable
      wr(BR + OFF_INTCTL, 4'hf, INT_ENABLE_VAL);
      rd(BR + OFF_INTCTL, 4'hf, 32'h0001_0010, 32'h10, "int idle");
      irq_pulse();
      chk("irq on", 32'h1, 32'(host_irq_o));
      rd(BR + OFF_INTCTL, 4'hf, 32'h0001_0010, 32'h0001_0010, "int pend");
      wr(BR + OFF_INTCTL, 4'hf, INT_ENABLE_VAL);
      chk("irq rearm", 32'h0, 32'(host_irq_o));
      irq_pulse();
      chk("irq again", 32'h1, 32'(host_irq_o));
      wr(BR + OFF_INTCTL, 4'hf, INT_DISABLE_VAL);
      irq_pulse();
      chk("irq off", 32'h0, 32'(host_irq_o));
      // two bytes at neighbouring addresses, then read both back
      for (int i = 0; i < 2; i++)
      begin
         nv_op(NV_CMD_LO, 8'h5a + 8'(i));
         nv_wait();
         nv_op(NV_CMD_HI, 8'h01);
         nv_wait();
         nv_op(NV_CMD_WRITE, 8'hc3 ^ 8'(i));
         rd(BR + OFF_NVCTL, 4'h8, 32'h8000_0000, 32'h8000_0000, "nv busy");
         nv_wait();
      end
      for (int i = 0; i < 2; i++)
      begin
         nv_op(NV_CMD_LO, 8'h5a + 8'(i));
         nv_wait();
         nv_op(NV_CMD_HI, 8'h01);
         nv_wait();
         wr(BR + OFF_NVCTL, 4'h8, {NV_CMD_READ, 24'h0});
         nv_wait();
         rd(BR + OFF_NVCTL, 4'h4, 32'h00ff_0000, {8'h0, 8'hc3 ^ 8'(i), 16'h0}, "nv");
      end
      // other sections, shared offsets split by direction
      wr(TM + OFF_CNT1, 4'hf, 32'h77);
      chk("cnt wr", 32'h2, 32'(counter_wr_o));
      chk("cnt data", 32'h77, 32'(counter_wdata_o));
      wr(TM + OFF_CNTMODE, 4'hf, 32'h5c);
      chk("cnt mode", 32'h8, 32'(counter_wr_o));
      rd(TM + OFF_CNT2, 4'hf, 32'hff, 32'h33, "cnt2");
      chk("cnt rd", 32'h4, 32'(counter_rd_o));
      wr(CT + OFF_ACQ, 4'h3, 32'h1234);
      chk("acq wr", 32'h1, 32'(acq_ctrl_wr_o));
      chk("acq", 32'h1234, 32'(acq_ctrl_o));
      rd(CT + OFF_ACQ, 4'h3, 32'hffff, 32'h12cb, "status");
      wr(CT + OFF_TRIG, 4'h1, 32'h1);
      chk("trig", 32'h1, 32'(soft_trig_o));
      wr(dio_base + OFF_DIO, 4'h3, 32'ha55a);
      chk("dout", 32'ha55a, 32'(dout_o));
      rd(dio_base + OFF_DIO, 4'h3, 32'hffff, 32'h5aa5, "din");
      wr(AD + OFF_AD, 4'h3, 32'h1111);
      wr(AD + OFF_DA2, 4'h3, 32'h2222);
      chk("da1", 32'h1111, 32'(da1_o));
      chk("da2", 32'h2222, 32'(da2_o));
      rd(AD + OFF_AD, 4'h3, 32'hffff, 32'h0123, "ad0");
      chk("ad pop", 32'h1, 32'(ad_rd_o));
      rd(AD + OFF_AD, 4'h3, 32'hffff, 32'h0124, "ad1");
      // unmapped space, then a relocated section
      cyc(1'b0, 16'h3000, 4'hf, 32'h0, 1'b0);
      chk("unmapped", 32'h0, io_rdata_o);
      dio_base = 16'h4000;
      wr(16'h4000, 4'h3, 32'h0f0f);
      cyc(1'b1, 16'h2020, 4'h3, 32'hffff, 1'b0);
      chk("moved dout", 32'h0f0f, 32'(dout_o));
      tally_and_finish();
   end
endmodule : tb_pdrd_reg_decode
